/* File: prog_pkg.sv */
// constants and types of the serial programming port
// assumes a 100 MHz core clock; times are kept in ns and turned into cycles here
package prog_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int FLASH_WRITE_WAIT_NS = 4500000;
    localparam int FUSE_WRITE_WAIT_NS = 4500000;
    localparam int EEPROM_WRITE_WAIT_NS = 9000000;
    localparam int ERASE_WAIT_NS = 9000000;
    // longest self-timed durations, so rounded down
    localparam int FLASH_WRITE_WAIT_CYC = FLASH_WRITE_WAIT_NS / CLK_PERIOD_NS;
    localparam int FUSE_WRITE_WAIT_CYC = FUSE_WRITE_WAIT_NS / CLK_PERIOD_NS;
    localparam int EEPROM_WRITE_WAIT_CYC = EEPROM_WRITE_WAIT_NS / CLK_PERIOD_NS;
    localparam int ERASE_WAIT_CYC = ERASE_WAIT_NS / CLK_PERIOD_NS;
    // ----------------------------------------------------------------
    // instruction codes
    // ----------------------------------------------------------------
    localparam logic [7:0] OPC_ENABLE = 8'hac;
    localparam logic [7:0] ENABLE_ECHO = 8'h53;
    localparam logic [2:0] SUB_ERASE = 3'h4;
    localparam logic [2:0] SUB_LOCK = 3'h7;
    localparam logic [7:0] SUB_FUSE_LO = 8'ha0;
    localparam logic [7:0] SUB_FUSE_HI = 8'ha8;
    localparam logic [7:0] SUB_RD_FUSE_HI = 8'h08;
    localparam logic [7:0] HSEL_MASK = 8'h08;
    localparam logic [7:0] OPC_RD_PROG = 8'h20;
    localparam logic [7:0] OPC_LD_PAGE = 8'h40;
    localparam logic [7:0] OPC_WR_PAGE = 8'h4c;
    localparam logic [7:0] OPC_RD_EEPROM = 8'ha0;
    localparam logic [7:0] OPC_WR_EEPROM = 8'hc0;
    localparam logic [7:0] OPC_RD_LOCK_FHI = 8'h58;
    localparam logic [7:0] OPC_RD_FUSE_LO = 8'h50;
    localparam logic [7:0] OPC_RD_SIG = 8'h30;
    localparam logic [7:0] OPC_RD_CAL = 8'h38;
    // ----------------------------------------------------------------
    // memories and reset values
    // ----------------------------------------------------------------
    localparam int FLASH_BYTES = 8192;
    localparam int EEPROM_BYTES = 512;
    localparam int PAGE_BYTES = 64;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [5:0] PAGE_LAST = 6'h3f;
    localparam logic [12:0] ERASE_LAST = 13'h1fff;
    localparam logic [4:0] BIT_LAST = 5'h1f;
    localparam logic [4:0] BIT_BYTE3 = 5'h17;
    localparam logic [5:0] LOCK_RST = 6'h3f;
    localparam logic [7:0] FUSE_LO_RST = 8'hff;
    localparam logic [7:0] FUSE_HI_RST = 8'hff;
    localparam logic [2:0] SYNC_RST = 3'h4;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_FLASH = 3'b001,
        OP_EEPROM = 3'b010,
        OP_FUSE_LO = 3'b011,
        OP_FUSE_HI = 3'b100,
        OP_LOCK = 3'b101,
        OP_ERASE = 3'b110
    } op_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_WAIT = 2'b01,
        PH_COMMIT = 2'b10
    } phase_t;
endpackage

/* File: prog_ctl_if.sv */
// signals between the port core, its pin synchroniser and its write timer
// all on the one core clock
`timescale 1ns/1ps
`default_nettype none
interface prog_ctl_if;
    logic sck_rise;
    logic sck_fall;
    logic mosi_lvl;
    logic prog_sel;
    logic tmr_start;
    logic [31:0] tmr_load;
    logic tmr_done;
    modport sync_src (output sck_rise, output sck_fall, output mosi_lvl, output prog_sel);
    modport tmr (input tmr_start, input tmr_load, output tmr_done);
    modport core (
        input sck_rise, input sck_fall, input mosi_lvl, input prog_sel,
        input tmr_done, output tmr_start, output tmr_load
    );
endinterface
`default_nettype wire

/* File: pin_sync.sv */
// three-stage synchroniser for the serial clock, data-in and reset pins
// pins are asynchronous to clk; a level counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic mosi,
    input wire logic prog_reset_n,
    prog_ctl_if.sync_src ctl
);
    import prog_pkg::*;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] lvl;
        logic sck_prv;
    } sync_st_t;

    localparam sync_st_t SYNC_ST_RST = '{SYNC_RST, SYNC_RST, SYNC_RST, SYNC_RST, 1'b0};

    sync_st_t st_ff;
    sync_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = {prog_reset_n, mosi, sck};
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < 3; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.lvl[i] = st_ff.s3[i];
            end
        end
        nxt_st.sck_prv = st_ff.lvl[0];
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_ff <= SYNC_ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ctl.sck_rise = st_ff.lvl[0] & ~st_ff.sck_prv;
    assign ctl.sck_fall = ~st_ff.lvl[0] & st_ff.sck_prv;
    assign ctl.mosi_lvl = st_ff.lvl[1];
    assign ctl.prog_sel = ~st_ff.lvl[2];
endmodule // pin_sync
`default_nettype wire

/* File: prog_timer.sv */
// self-timed write duration counter
// a start loads the count; done pulses for one cycle when it runs out
`timescale 1ns/1ps
`default_nettype none
module prog_timer (
    input wire logic clk,
    input wire logic reset,
    prog_ctl_if.tmr ctl
);
    typedef struct packed {
        logic run;
        logic [31:0] cnt;
    } tmr_st_t;

    tmr_st_t st_ff;
    tmr_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (ctl.tmr_start) begin
            nxt_st.run = 1'b1;
            nxt_st.cnt = ctl.tmr_load;
        end else if (st_ff.run) begin
            nxt_st.cnt = st_ff.cnt - 32'h1;
            if (st_ff.cnt <= 32'h1) begin
                nxt_st.run = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ctl.tmr_done = st_ff.run & (st_ff.cnt <= 32'h1);
endmodule // prog_timer
`default_nettype wire

/* File: serial_prog_port.sv */
// serial in-system programming port: four-byte instructions over sck/mosi/miso
// assumes the programmer drives sck slower than three core cycles per phase
`timescale 1ns/1ps
`default_nettype none
module serial_prog_port #(
    parameter int unsigned FLASH_CYC = prog_pkg::FLASH_WRITE_WAIT_CYC,
    parameter int unsigned FUSE_CYC = prog_pkg::FUSE_WRITE_WAIT_CYC,
    parameter int unsigned EEPROM_CYC = prog_pkg::EEPROM_WRITE_WAIT_CYC,
    parameter int unsigned ERASE_CYC = prog_pkg::ERASE_WAIT_CYC,
    // identity bytes: arbitrary neutral values
    parameter logic [7:0] SIG_BYTE0 = 8'h11,
    parameter logic [7:0] SIG_BYTE1 = 8'h22,
    parameter logic [7:0] SIG_BYTE2 = 8'h33,
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic mosi,
    input wire logic prog_reset_n,
    output logic miso,
    output logic miso_oe,
    output logic prog_enabled,
    output logic prog_busy
);
    import prog_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic enabled;
        logic [4:0] bitcnt;
        logic [31:0] rx;
        logic [7:0] tx;
        logic miso;
        op_t op;
        phase_t phase;
        logic [12:0] step;
        logic [6:0] page;
        logic [8:0] eaddr;
        logic [7:0] wdata;
        logic [5:0] lock;
        logic [7:0] fuse_lo;
        logic [7:0] fuse_hi;
    } core_st_t;

    localparam core_st_t CORE_RST = '{
        enabled: 1'b0, bitcnt: 5'h0, rx: 32'h0, tx: 8'h0, miso: 1'b0,
        op: OP_NONE, phase: PH_IDLE, step: 13'h0, page: 7'h0, eaddr: 9'h0,
        wdata: 8'h0, lock: LOCK_RST, fuse_lo: FUSE_LO_RST, fuse_hi: FUSE_HI_RST
    };

    core_st_t st_ff;
    core_st_t nxt_st;

    logic [7:0] flash_mem [0:FLASH_BYTES-1];
    logic [7:0] eeprom_mem [0:EEPROM_BYTES-1];
    logic [7:0] page_buf [0:PAGE_BYTES-1];

    logic [31:0] rx_nxt;
    logic [7:0] f1, f2, f3, f4;
    logic [7:0] q1, q2, q3;
    logic [12:0] rd_fa;
    logic [8:0] rd_ea;
    logic [7:0] rd_val;
    logic is_rd;
    logic byte_done;
    logic frame_done;
    logic fl_we, ee_we, pb_we;
    logic [12:0] fl_wa;
    logic [8:0] ee_wa;
    logic [5:0] pb_wa;
    logic [7:0] fl_wd, ee_wd, pb_wd;

    prog_ctl_if ctl ();

    pin_sync u_sync (
        .clk(clk),
        .reset(reset),
        .sck(sck),
        .mosi(mosi),
        .prog_reset_n(prog_reset_n),
        .ctl(ctl.sync_src)
    );

    prog_timer u_timer (
        .clk(clk),
        .reset(reset),
        .ctl(ctl.tmr)
    );

    // strip the high/low byte select from an opcode
    function automatic logic [7:0] opc(input logic [7:0] b);
        return b & ~HSEL_MASK;
    endfunction

    // ----------------------------------------------------------------
    // frame view
    // ----------------------------------------------------------------
    // rising-edge sample
    assign rx_nxt = {st_ff.rx[30:0], ctl.mosi_lvl};
    assign byte_done = ctl.sck_rise && (st_ff.bitcnt[2:0] == BIT_LAST[2:0]);
    assign frame_done = ctl.sck_rise && (st_ff.bitcnt == BIT_LAST);
    assign {f1, f2, f3, f4} = rx_nxt;
    assign {q1, q2, q3} = rx_nxt[23:0];
    assign rd_fa = {q2[3:0], q3, q1[3]};
    assign rd_ea = {q2[0], q3};

    // ----------------------------------------------------------------
    // read data, chosen when byte three is complete
    // ----------------------------------------------------------------
    always_comb begin
        is_rd = st_ff.enabled;
        rd_val = ERASED;
        if (opc(q1) == OPC_RD_PROG) begin
            if (st_ff.op == OP_ERASE
                    || (st_ff.op == OP_FLASH && rd_fa[12:6] == st_ff.page)) begin
                rd_val = ERASED;
            end else begin
                rd_val = flash_mem[rd_fa];
            end
        end else if (q1 == OPC_RD_EEPROM) begin
            if (st_ff.op == OP_ERASE
                    || (st_ff.op == OP_EEPROM && rd_ea == st_ff.eaddr)) begin
                rd_val = ERASED;
            end else begin
                rd_val = eeprom_mem[rd_ea];
            end
        end else if (q1 == OPC_RD_LOCK_FHI) begin
            rd_val = (q2 == SUB_RD_FUSE_HI) ? st_ff.fuse_hi : {2'b11, st_ff.lock};
        end else if (q1 == OPC_RD_FUSE_LO) begin
            rd_val = st_ff.fuse_lo;
        end else if (q1 == OPC_RD_SIG) begin
            unique case (q3[1:0])
                2'h0: rd_val = SIG_BYTE0;
                2'h1: rd_val = SIG_BYTE1;
                2'h2: rd_val = SIG_BYTE2;
                2'h3: rd_val = ERASED;
            endcase
        end else if (q1 == OPC_RD_CAL) begin
            rd_val = CAL_BYTE;
        end else begin
            is_rd = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        ctl.tmr_start = 1'b0;
        ctl.tmr_load = 32'h0;
        fl_we = 1'b0;
        fl_wa = 13'h0;
        fl_wd = ERASED;
        ee_we = 1'b0;
        ee_wa = 9'h0;
        ee_wd = ERASED;
        pb_we = 1'b0;
        pb_wa = 6'h0;
        pb_wd = ERASED;

        // shifter
        if (ctl.sck_rise) begin
            nxt_st.rx = rx_nxt;
            nxt_st.bitcnt = st_ff.bitcnt + 5'h1;
        end
        if (ctl.sck_fall) begin
            nxt_st.miso = st_ff.tx[7];
            nxt_st.tx = {st_ff.tx[6:0], 1'b0};
        end
        if (byte_done) begin
            if (st_ff.bitcnt == BIT_BYTE3 && is_rd) begin
                nxt_st.tx = rd_val;
            end else begin
                nxt_st.tx = rx_nxt[7:0];
            end
        end

        // instruction decode; writes only when enabled and idle
        if (frame_done) begin
            if (f1 == OPC_ENABLE && f2 == ENABLE_ECHO) begin
                nxt_st.enabled = 1'b1;
            end else if (st_ff.enabled && st_ff.phase == PH_IDLE) begin
                if (f1 == OPC_ENABLE && f2[7:5] == SUB_ERASE) begin
                    nxt_st.op = OP_ERASE;
                    ctl.tmr_start = 1'b1;
                    ctl.tmr_load = 32'(ERASE_CYC);
                end else if (f1 == OPC_ENABLE && f2[7:5] == SUB_LOCK) begin
                    nxt_st.op = OP_LOCK;
                    ctl.tmr_start = 1'b1;
                    ctl.tmr_load = 32'(FUSE_CYC);
                end else if (f1 == OPC_ENABLE && f2 == SUB_FUSE_LO) begin
                    nxt_st.op = OP_FUSE_LO;
                    ctl.tmr_start = 1'b1;
                    ctl.tmr_load = 32'(FUSE_CYC);
                end else if (f1 == OPC_ENABLE && f2 == SUB_FUSE_HI) begin
                    nxt_st.op = OP_FUSE_HI;
                    ctl.tmr_start = 1'b1;
                    ctl.tmr_load = 32'(FUSE_CYC);
                end else if (opc(f1) == OPC_LD_PAGE) begin
                    pb_we = 1'b1;
                    pb_wa = {f3[4:0], f1[3]};
                    pb_wd = f4;
                end else if (f1 == OPC_WR_PAGE) begin
                    nxt_st.op = OP_FLASH;
                    nxt_st.page = {f2[3:0], f3[7:5]};
                    ctl.tmr_start = 1'b1;
                    ctl.tmr_load = 32'(FLASH_CYC);
                end else if (f1 == OPC_WR_EEPROM) begin
                    nxt_st.op = OP_EEPROM;
                    nxt_st.eaddr = {f2[0], f3};
                    ctl.tmr_start = 1'b1;
                    ctl.tmr_load = 32'(EEPROM_CYC);
                end
                nxt_st.wdata = f4;
                if (ctl.tmr_start) begin
                    nxt_st.phase = PH_WAIT;
                end
            end
        end

        // self-timed write sequencing
        unique case (st_ff.phase)
            PH_IDLE: begin
            end
            PH_WAIT: begin
                if (ctl.tmr_done) begin
                    nxt_st.phase = PH_IDLE;
                    nxt_st.op = OP_NONE;
                    nxt_st.step = 13'h0;
                    unique case (st_ff.op)
                        OP_FLASH, OP_ERASE: begin
                            nxt_st.phase = PH_COMMIT;
                            nxt_st.op = st_ff.op;
                        end
                        OP_EEPROM: begin
                            ee_we = 1'b1;
                            ee_wa = st_ff.eaddr;
                            ee_wd = st_ff.wdata;
                        end
                        OP_FUSE_LO: nxt_st.fuse_lo = st_ff.wdata;
                        OP_FUSE_HI: nxt_st.fuse_hi = st_ff.wdata;
                        // zero bits stick until a chip erase
                        OP_LOCK: nxt_st.lock = st_ff.lock & st_ff.wdata[5:0];
                        default: begin
                        end
                    endcase
                end
            end
            PH_COMMIT: begin
                nxt_st.step = st_ff.step + 13'h1;
                if (st_ff.op == OP_FLASH) begin
                    fl_we = 1'b1;
                    fl_wa = {st_ff.page, st_ff.step[5:0]};
                    fl_wd = page_buf[st_ff.step[5:0]];
                    pb_we = 1'b1;
                    pb_wa = st_ff.step[5:0];
                    if (st_ff.step[5:0] == PAGE_LAST) begin
                        nxt_st.phase = PH_IDLE;
                        nxt_st.op = OP_NONE;
                    end
                end else begin
                    fl_we = 1'b1;
                    fl_wa = st_ff.step;
                    ee_we = (st_ff.step[12:9] == 4'h0);
                    ee_wa = st_ff.step[8:0];
                    pb_we = (st_ff.step[12:6] == 7'h0);
                    pb_wa = st_ff.step[5:0];
                    if (st_ff.step == ERASE_LAST) begin
                        nxt_st.lock = LOCK_RST;
                        nxt_st.phase = PH_IDLE;
                        nxt_st.op = OP_NONE;
                    end
                end
            end
            default: begin
                nxt_st.phase = PH_IDLE;
                nxt_st.op = OP_NONE;
            end
        endcase

        // port live only with reset pin low
        if (!ctl.prog_sel) begin
            nxt_st.enabled = 1'b0;
            nxt_st.bitcnt = 5'h0;
            nxt_st.tx = 8'h0;
            nxt_st.miso = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_ff <= CORE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // memories
    // ----------------------------------------------------------------
    // no reset on the arrays: contents are unknown until a chip erase
    always_ff @(posedge clk) begin
        if (fl_we) begin
            flash_mem[fl_wa] <= fl_wd;
        end
        if (ee_we) begin
            eeprom_mem[ee_wa] <= ee_wd;
        end
        if (pb_we) begin
            page_buf[pb_wa] <= pb_wd;
        end
    end

    assign miso = st_ff.miso;
    assign miso_oe = ctl.prog_sel;
    assign prog_enabled = st_ff.enabled;
    assign prog_busy = (st_ff.phase != PH_IDLE);
endmodule // serial_prog_port
`default_nettype wire

/* File: serial_prog_port_chk.sv */
// port-level checker for the serial programming port
// assumes one core clock; the pins come from an external programmer
`timescale 1ns/1ps
`default_nettype none
module serial_prog_port_chk #(
    parameter int unsigned FUSE_CYC = 20
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic mosi,
    input wire logic prog_reset_n,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic prog_enabled,
    input wire logic prog_busy
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // length of the current busy stretch, shortest legal one is the fuse wait
    logic [31:0] busy_cnt_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_cnt_ff <= 32'h0;
        end else begin
            busy_cnt_ff <= prog_busy ? busy_cnt_ff + 32'h1 : 32'h0;
        end
    end
    property p_miso_fall;
        (!prog_reset_n && $past(!prog_reset_n, 6) && $changed(miso)) |-> !$past(sck, 2);
    endproperty
    a_miso_fall: assert property (p_miso_fall) else $error("miso moved off a clock fall");
    property p_miso_hold;
        // output settles one cycle after the rise, then holds through the high phase
        $rose(sck) |=> ##1 $stable(miso) [*3];
    endproperty
    a_miso_hold: assert property (p_miso_hold) else $error("miso moved while clock high");
    property p_oe_on;
        !prog_reset_n [*8] |-> miso_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso not driven in programming mode");
    property p_pin_idle;
        prog_reset_n [*8] |-> !miso_oe && !miso && !prog_enabled;
    endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("port active outside mode");
    property p_en_rise;
        $rose(prog_enabled) |-> $past(sck, 3) && !prog_reset_n;
    endproperty
    a_en_rise: assert property (p_en_rise) else $error("enable rose off a frame end");
    property p_en_fall;
        $fell(prog_enabled) |-> $past(prog_reset_n, 2);
    endproperty
    a_en_fall: assert property (p_en_fall) else $error("enable dropped without pin reset");
    property p_busy_start;
        $rose(prog_busy) |-> $past(sck, 3) && prog_enabled;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("write began wrongly");
    property p_busy_len;
        $fell(prog_busy) |-> busy_cnt_ff >= FUSE_CYC;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write ended too early");
endmodule // serial_prog_port_chk
bind serial_prog_port serial_prog_port_chk #(.FUSE_CYC(FUSE_CYC)) i_serial_prog_port_chk (
    .clk(clk), .reset(reset), .sck(sck), .mosi(mosi), .prog_reset_n(prog_reset_n),
    .miso(miso), .miso_oe(miso_oe), .prog_enabled(prog_enabled), .prog_busy(prog_busy)
);
`default_nettype wire

/* File: prog_master.sv */
// model of the external programmer acting as serial master
// assumes the core clock runs; sck phases are four core cycles
`timescale 1ns/1ps
`default_nettype none
module prog_master (
    input wire logic clk,
    input wire logic miso,
    output logic sck,
    output logic mosi,
    output logic [31:0] rx,
    output logic rx_done
);
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        rx = 32'h0;
        rx_done = 1'b0;
    end
    // whole frame, msb first, long phases
    task automatic xfer(input logic [31:0] tx);
        @(posedge clk);
        for (int i = 31; i >= 0; i--) begin
            sck <= 1'b0;
            mosi <= tx[i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            // output trails the fall by the pin synchroniser, so take it late in the high phase
            rx[i] <= miso;
        end
        // clock parks low; data shows the inverse so no stale bit looks valid
        sck <= 1'b0;
        mosi <= ~tx[0];
        repeat (4) @(posedge clk);
        rx_done <= 1'b1;
        @(posedge clk);
        rx_done <= 1'b0;
    endtask
endmodule // prog_master
`default_nettype wire

/* File: serial_prog_port_tb.sv */
// self-checking bench of the serial programming port
// assumes the programmer model drives sck and mosi; write waits shortened
`timescale 1ns/1ps
`default_nettype none
module serial_prog_port_tb;
    import prog_pkg::*;
    // identity bytes: arbitrary values
    localparam logic [7:0] SIG [4] = '{8'h5a, 8'h6b, 8'h7c, 8'hff};
    localparam logic [7:0] CAL = 8'h91;
    logic clk = 1'b0, reset = 1'b1, prog_reset_n = 1'b1;
    logic sck, mosi, miso, miso_oe, prog_enabled, prog_busy, rx_done;
    logic [31:0] rx, v, seed = 32'hcf33;
    logic [9:0] notes [$];
    logic [9:0] note;
    logic [8:0] ea;
    logic [11:0] fa;
    logic [7:0] d;
    logic [7:0] ee_d;
    logic [7:0] wr_sub [3] = '{8'ha0, 8'ha8, 8'he0};
    logic [15:0] rd_cmd [3] = '{16'h5000, 16'h5808, 16'h5800};
    int fails = 0, n_compared = 0;
    always #5 clk = ~clk;
    serial_prog_port #(.FLASH_CYC(400), .FUSE_CYC(20), .EEPROM_CYC(400), .ERASE_CYC(40),
        .SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2]), .CAL_BYTE(CAL)
    ) i_serial_prog_port (.clk(clk), .reset(reset), .sck(sck), .mosi(mosi),
        .prog_reset_n(prog_reset_n), .miso(miso), .miso_oe(miso_oe),
        .prog_enabled(prog_enabled), .prog_busy(prog_busy));
    prog_master i_prog_master (.clk(clk), .miso(miso), .sck(sck), .mosi(mosi), .rx(rx),
        .rx_done(rx_done));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // lane 0 is byte four, lane 1 byte three, lane 3 unchecked
    task automatic send(input logic [31:0] tx, input logic [1:0] lane, input logic [7:0] e);
        notes.push_back({lane, e});
        i_prog_master.xfer(tx);
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 10000 && prog_busy !== 1'b0; k++) @(posedge clk);
        if (k == 10000) begin
            fails++;
            results();
        end
    endtask
    always @(posedge clk) begin
        if (rx_done === 1'b1) begin
            note = notes.pop_front();
            if (note[9:8] != 2'd3) cmp("miso byte", note[7:0], rx[8*note[9:8] +: 8]);
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        prog_reset_n <= 1'b0;
        repeat (10) @(posedge clk);
        cmp("miso_oe", 8'h01, {7'h0, miso_oe});
        send({OPC_ENABLE, ENABLE_ECHO, 16'h0}, 2'd1, ENABLE_ECHO);
        cmp("prog_enabled", 8'h01, {7'h0, prog_enabled});
        send({OPC_ENABLE, SUB_ERASE, 21'h0}, 2'd3, 8'h0);
        cmp("prog_busy", 8'h01, {7'h0, prog_busy});
        wait_idle();
        v = rnd();
        ea = v[8:0];
        fa = v[20:9];
        send({OPC_RD_EEPROM, 7'h0, ea, 8'h0}, 2'd0, ERASED);
        send({OPC_RD_PROG, 4'h0, fa, 8'h0}, 2'd0, ERASED);
        $display("test erase done");
        d = v[31:24];
        ee_d = d;
        send({OPC_WR_EEPROM, 7'h0, ea, d}, 2'd3, 8'h0);
        send({OPC_RD_EEPROM, 7'h0, ea, 8'h0}, 2'd0, ERASED);
        wait_idle();
        send({OPC_RD_EEPROM, 7'h0, ea, 8'h0}, 2'd0, d);
        $display("test eeprom done");
        v = rnd();
        send({OPC_LD_PAGE, 11'h0, fa[4:0], v[7:0]}, 2'd3, 8'h0);
        send({OPC_LD_PAGE | HSEL_MASK, 11'h0, fa[4:0], v[15:8]}, 2'd3, 8'h0);
        send({OPC_WR_PAGE, 4'h0, fa, 8'h0}, 2'd3, 8'h0);
        send({OPC_RD_PROG, 4'h0, fa, 8'h0}, 2'd0, ERASED);
        wait_idle();
        send({OPC_RD_PROG, 4'h0, fa, 8'h0}, 2'd0, v[7:0]);
        send({OPC_RD_PROG | HSEL_MASK, 4'h0, fa, 8'h0}, 2'd0, v[15:8]);
        $display("test flash done");
        for (int i = 0; i < 3; i++) begin
            v = rnd();
            d = (i == 2) ? {2'b11, v[5:0]} : v[7:0];
            send({OPC_ENABLE, wr_sub[i], 8'h0, d}, 2'd3, 8'h0);
            wait_idle();
            send({rd_cmd[i], 16'h0}, 2'd0, d);
        end
        for (int b = 0; b < 4; b++) send({OPC_RD_SIG, 14'h0, b[1:0], 8'h0}, 2'd0, SIG[b]);
        send({OPC_RD_CAL, 24'h0}, 2'd0, CAL);
        $display("test fuse lock id done");
        prog_reset_n <= 1'b1;
        repeat (12) @(posedge clk);
        cmp("prog_enabled", 8'h00, {7'h0, prog_enabled});
        cmp("miso_oe", 8'h00, {7'h0, miso_oe});
        prog_reset_n <= 1'b0;
        repeat (12) @(posedge clk);
        send({OPC_WR_EEPROM, 7'h0, ea, ~ee_d}, 2'd3, 8'h0);
        send({OPC_ENABLE, ENABLE_ECHO, 16'h0}, 2'd1, ENABLE_ECHO);
        send({OPC_RD_EEPROM, 7'h0, ea, 8'h0}, 2'd0, ee_d);
        // let the watcher take the last answer before the verdict
        repeat (2) @(posedge clk);
        $display("test refusal done");
        results();
    end
endmodule // serial_prog_port_tb
`default_nettype wire
